/* File: hdl/dmm_pkg.sv */
// Package with constants and types for the data memory map and nonvolatile byte port.
package dmm_pkg;

  // ==========================================================================
  // Memory map
  localparam int unsigned PROG_BYTES      = 8192;
  localparam int unsigned PROG_WORDS      = 4096;
  localparam int unsigned PC_WIDTH        = 12;
  localparam logic [15:0] REGIO_LAST      = 16'h005f;
  localparam logic [15:0] SRAM_FIRST      = 16'h0060;
  localparam logic [15:0] SRAM_LAST       = 16'h025f;
  localparam logic [15:0] EXT_FIRST       = 16'h0260;
  localparam int unsigned SRAM_WORDS      = 512;
  localparam int unsigned SRAM_AW         = 9;
  localparam logic [5:0]  DISP_MAX        = 6'h3f;

  // ==========================================================================
  // Access cycle figures
  localparam logic [3:0]  INT_CYCLES      = 4'h2;
  localparam logic [3:0]  EXT_BASE_EXTRA  = 4'h1;
  localparam logic [3:0]  STACK_BASE_EXTRA = 4'h3;

  // ==========================================================================
  // Nonvolatile byte port
  localparam int unsigned NV_BYTES        = 512;
  localparam int unsigned NV_AW           = 9;
  localparam logic [2:0]  NV_READ_STALL   = 3'h4;
  localparam logic [2:0]  NV_WRITE_STALL  = 3'h2;
  localparam logic [2:0]  NV_ARM_CYCLES   = 3'h4;
  localparam int unsigned NV_WRITE_OSC    = 8448;
  localparam logic [7:0]  NV_CTRL_ARM_BIT = 8'h04;
  localparam logic [7:0]  NV_CTRL_WR_BIT  = 8'h02;
  localparam logic [7:0]  NV_CTRL_RD_BIT  = 8'h01;
  localparam logic [7:0]  MCU_SRE_BIT     = 8'h80;

  // I/O register indices inside the I/O space (index, not data address).
  localparam logic [5:0]  IO_MCU_CTRL     = 6'h35;
  localparam logic [5:0]  IO_NV_ADDR_HIGH = 6'h1f;
  localparam logic [5:0]  IO_NV_ADDR_LOW  = 6'h1e;
  localparam logic [5:0]  IO_NV_DATA      = 6'h1d;
  localparam logic [5:0]  IO_NV_CTRL      = 6'h1c;

  // Pointer register selection and addressing mode.
  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} dmm_ptr_type;
  typedef enum logic [2:0] {AM_DIRECT, AM_INDIRECT, AM_DISP, AM_PREDEC, AM_POSTINC} dmm_mode_type;

  // One data request from the core.
  typedef struct packed {
    logic         valid;
    logic         write;
    logic         stack;
    logic         pc_xfer;
    dmm_mode_type mode;
    dmm_ptr_type  ptr;
    logic [15:0]  direct;
    logic [5:0]   disp;
    logic [7:0]   wdata;
  } dmm_req_type;

endpackage

/* File: hdl/dmm_top.sv */
// Data address decoder, access cycle timing and nonvolatile byte access port.
`timescale 1ns/1ps
// How it works
// - Program store is 8K bytes seen as 4K sixteen-bit words.
// - Program counter is twelve bits and spans all 4K words.
// - Addresses 0..95 select register file and I/O, next 512 internal SRAM.
// - External SRAM fills the rest of the 64K space above internal SRAM.
// - Addresses beyond internal memory go to external SRAM with same operations.
// - External strobes stay inactive throughout internal accesses.
// - External interface works only while ext_mem_enable is set.
// - Zero-wait external byte access costs one extra cycle.
// - Zero-wait external stack adds three cycles to calls, returns, interrupts.
// - One to three wait states add two to four cycles per byte.
// - With wait states, stacked PC transfers add five, seven or nine cycles.
// - Displacement address is X, Y or Z plus unsigned offset up to 63.
// - Pre-decrement and post-increment write adjusted pointer back.
// - All addressing modes reach registers, I/O and internal SRAM.
// - Internal SRAM access completes in two cycles.
// - Nonvolatile store holds 512 individually accessed bytes, separate space.
// - A nonvolatile read stalls the core four cycles.
// - A nonvolatile write stalls the core two cycles.
// - Write strobes without the arming sequence are ignored.
// - The nine-bit nonvolatile address selects bytes 0 to 511 linearly.
// - Address bits 15..9 ignore writes and read as zero.
// - Data register supplies write bytes and captures read bytes.
// - Write starts only while armed; arm clears four cycles after set.
// - Read strobe loads data register within the same instruction.
// - Write strobe bit clears when the self-timed write finishes.
// - During a write, reads are blocked and address changes refused.
module dmm_top (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire dmm_pkg::dmm_req_type req,
  input  wire logic [1:0]         wait_states,
  input  wire logic               nv_osc_tick,
  input  wire logic [7:0]         ext_rdata,
  input  wire logic [dmm_pkg::PC_WIDTH-1:0] pc_next,
  input  wire logic               pc_load,
  output logic [dmm_pkg::PC_WIDTH-1:0] program_counter,
  output logic [7:0]              rdata,
  output logic                    done,
  output logic                    cpu_stall,
  output logic [15:0]             ext_addr,
  output logic [7:0]              ext_wdata,
  output logic                    ext_rd_n,
  output logic                    ext_wr_n,
  output logic [15:0]             ptr_x,
  output logic [15:0]             ptr_y,
  output logic [15:0]             ptr_z
);

  // ==========================================================================
  // Helpers
  function automatic logic is_external(input logic [15:0] a, input logic en);
    is_external = en && (a >= dmm_pkg::EXT_FIRST);
  endfunction

  function automatic logic [3:0] ext_extra(input logic [1:0] ws, input logic pcx);
    logic [3:0] per;
    per = dmm_pkg::EXT_BASE_EXTRA + 4'(ws);
    if (pcx) ext_extra = (ws == 2'h0) ? dmm_pkg::STACK_BASE_EXTRA : 4'(2 * ws + 3);
    else ext_extra = per;
  endfunction

  // ==========================================================================
  // State
  logic [7:0]  sram [dmm_pkg::SRAM_WORDS];
  logic [7:0]  regio [96];
  logic [7:0]  nv_mem [dmm_pkg::NV_BYTES];
  logic [7:0]  mcu_control_reg;
  logic [dmm_pkg::NV_AW-1:0] nv_byte_address;
  logic [7:0]  nv_byte_data;
  logic        nv_write_arm, nv_write_strobe;
  logic [2:0]  arm_cnt, stall_cnt;
  logic [13:0] osc_cnt;
  logic [3:0]  busy_cnt;
  logic        busy_ext, busy_wr;
  logic [15:0] busy_addr;
  logic [7:0]  busy_wdata;
  logic        ext_mem_enable;

  assign ext_mem_enable = mcu_control_reg[7];

  // Effective address and pointer update.
  logic [15:0] base, eff, next_ptr;
  logic        ptr_upd;
  always_comb begin
    unique case (req.ptr)
      dmm_pkg::PTR_X: base = ptr_x;
      dmm_pkg::PTR_Y: base = ptr_y;
      default:        base = ptr_z;
    endcase
    next_ptr = base;
    ptr_upd  = 1'b0;
    unique case (req.mode)
      dmm_pkg::AM_DIRECT:   eff = req.direct;
      dmm_pkg::AM_INDIRECT: eff = base;
      dmm_pkg::AM_DISP:     eff = base + {10'h000, req.disp};
      dmm_pkg::AM_PREDEC: begin
        eff = base - 16'h0001;
        next_ptr = eff;
        ptr_upd = 1'b1;
      end
      default: begin
        eff = base;
        next_ptr = base + 16'h0001;
        ptr_upd = 1'b1;
      end
    endcase
  end

  // Register file byte lookup and I/O decode for reads.
  logic [7:0] io_rd;
  logic [5:0] io_idx;
  always_comb begin
    io_idx = 6'(eff - 16'h0020);
    if (eff < 16'h0020) begin
      // The upper six general registers are the live pointer bytes.
      unique case (eff[4:0])
        5'h1a:   io_rd = ptr_x[7:0];
        5'h1b:   io_rd = ptr_x[15:8];
        5'h1c:   io_rd = ptr_y[7:0];
        5'h1d:   io_rd = ptr_y[15:8];
        5'h1e:   io_rd = ptr_z[7:0];
        5'h1f:   io_rd = ptr_z[15:8];
        default: io_rd = regio[eff[6:0]];
      endcase
    end else if (io_idx == dmm_pkg::IO_MCU_CTRL) io_rd = mcu_control_reg;
    else if (io_idx == dmm_pkg::IO_NV_ADDR_HIGH) io_rd = {7'h00, nv_byte_address[8]};
    else if (io_idx == dmm_pkg::IO_NV_ADDR_LOW) io_rd = nv_byte_address[7:0];
    else if (io_idx == dmm_pkg::IO_NV_DATA) io_rd = nv_byte_data;
    else if (io_idx == dmm_pkg::IO_NV_CTRL)
      io_rd = {5'h00, nv_write_arm, nv_write_strobe, 1'b0};
    else io_rd = regio[eff[6:0]];
  end

  // Requests are only taken when no access or stall is running.
  logic take, is_io_wr, nv_rd_go, nv_wr_go;
  assign take     = req.valid && (busy_cnt == 4'h0) && (stall_cnt == 3'h0);
  assign is_io_wr = take && req.write && (eff >= 16'h0020) && (eff <= dmm_pkg::REGIO_LAST);
  assign nv_rd_go = is_io_wr && (io_idx == dmm_pkg::IO_NV_CTRL) && req.wdata[0]
                    && !nv_write_strobe;
  assign nv_wr_go = is_io_wr && (io_idx == dmm_pkg::IO_NV_CTRL) && req.wdata[1]
                    && nv_write_arm && !nv_write_strobe;

  // ==========================================================================
  // Sequential logic: memory arrays and registers.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mcu_control_reg <= 8'h00;
      nv_write_arm    <= 1'b0;
      nv_write_strobe <= 1'b0;
      arm_cnt         <= 3'h0;
      stall_cnt       <= 3'h0;
      osc_cnt         <= 14'h0000;
      busy_cnt        <= 4'h0;
      busy_ext        <= 1'b0;
      busy_wr         <= 1'b0;
      busy_addr       <= 16'h0000;
      busy_wdata      <= 8'h00;
      nv_byte_address <= 9'h000;
      nv_byte_data    <= 8'h00;
      rdata           <= 8'h00;
      done            <= 1'b0;
      cpu_stall       <= 1'b0;
      ext_addr        <= 16'h0000;
      ext_wdata       <= 8'h00;
      ext_rd_n        <= 1'b1;
      ext_wr_n        <= 1'b1;
      ptr_x           <= 16'h0000;
      ptr_y           <= 16'h0000;
      ptr_z           <= 16'h0000;
      program_counter <= '0;
    end else begin
      done <= 1'b0;
      if (pc_load) program_counter <= pc_next;
      // Arm window closes four cycles after software sets it.
      if (arm_cnt != 3'h0) begin
        arm_cnt <= arm_cnt - 3'h1;
        if (arm_cnt == 3'h1) nv_write_arm <= 1'b0;
      end
      if (stall_cnt != 3'h0) stall_cnt <= stall_cnt - 3'h1;
      cpu_stall <= (stall_cnt > 3'h1) || nv_rd_go || nv_wr_go;
      // Self-timed write counted on the calibrated oscillator tick.
      if (nv_write_strobe && nv_osc_tick) begin
        if (osc_cnt == 14'(dmm_pkg::NV_WRITE_OSC - 1)) begin
          nv_write_strobe <= 1'b0;
          nv_mem[nv_byte_address] <= nv_byte_data;
          osc_cnt <= 14'h0000;
        end else osc_cnt <= osc_cnt + 14'h0001;
      end
      // Multi-cycle access in flight.
      if (busy_cnt != 4'h0) begin
        busy_cnt <= busy_cnt - 4'h1;
        if (busy_cnt == 4'h1) begin
          done     <= 1'b1;
          ext_rd_n <= 1'b1;
          ext_wr_n <= 1'b1;
          if (busy_ext && !busy_wr) rdata <= ext_rdata;
          if (!busy_ext && !busy_wr) rdata <= sram[9'(busy_addr - dmm_pkg::SRAM_FIRST)];
        end
      end
      if (take) begin
        if (ptr_upd) begin
          unique case (req.ptr)
            dmm_pkg::PTR_X: ptr_x <= next_ptr;
            dmm_pkg::PTR_Y: ptr_y <= next_ptr;
            default:        ptr_z <= next_ptr;
          endcase
        end
        if (eff <= dmm_pkg::REGIO_LAST) begin
          done <= 1'b1;
          if (!req.write) rdata <= io_rd;
          else if (eff < 16'h0020) begin
            regio[eff[6:0]] <= req.wdata;
            // Pointer bytes are kept in flops so the address path never waits on the array.
            unique case (eff[4:0])
              5'h1a:   ptr_x[7:0]  <= req.wdata;
              5'h1b:   ptr_x[15:8] <= req.wdata;
              5'h1c:   ptr_y[7:0]  <= req.wdata;
              5'h1d:   ptr_y[15:8] <= req.wdata;
              5'h1e:   ptr_z[7:0]  <= req.wdata;
              5'h1f:   ptr_z[15:8] <= req.wdata;
              default: ;
            endcase
          end else unique case (io_idx)
            dmm_pkg::IO_MCU_CTRL: mcu_control_reg <= req.wdata;
            dmm_pkg::IO_NV_ADDR_HIGH:
              if (!nv_write_strobe) nv_byte_address[8] <= req.wdata[0];
            dmm_pkg::IO_NV_ADDR_LOW:
              if (!nv_write_strobe) nv_byte_address[7:0] <= req.wdata;
            dmm_pkg::IO_NV_DATA: nv_byte_data <= req.wdata;
            dmm_pkg::IO_NV_CTRL: begin
              if (req.wdata[2] && !req.wdata[1]) begin
                nv_write_arm <= 1'b1;
                arm_cnt <= dmm_pkg::NV_ARM_CYCLES;
              end
              if (nv_rd_go) begin
                nv_byte_data <= nv_mem[nv_byte_address];
                stall_cnt <= dmm_pkg::NV_READ_STALL;
              end
              if (nv_wr_go) begin
                nv_write_strobe <= 1'b1;
                nv_write_arm <= 1'b0;
                arm_cnt <= 3'h0;
                stall_cnt <= dmm_pkg::NV_WRITE_STALL;
              end
            end
            default: regio[eff[6:0]] <= req.wdata;
          endcase
        end else if (is_external(eff, ext_mem_enable)) begin
          busy_ext   <= 1'b1;
          busy_wr    <= req.write;
          busy_addr  <= eff;
          busy_cnt   <= dmm_pkg::INT_CYCLES - 4'h1 + ext_extra(wait_states, req.pc_xfer);
          ext_addr   <= eff;
          ext_wdata  <= req.wdata;
          ext_rd_n   <= req.write;
          ext_wr_n   <= !req.write;
        end else if (eff <= dmm_pkg::SRAM_LAST) begin
          busy_ext  <= 1'b0;
          busy_wr   <= req.write;
          busy_addr <= eff;
          busy_cnt  <= dmm_pkg::INT_CYCLES - 4'h1;
          if (req.write) sram[9'(eff - dmm_pkg::SRAM_FIRST)] <= req.wdata;
        end else begin
          done <= 1'b1;
          rdata <= 8'h00;
        end
      end
    end
  end

  // ==========================================================================
  // Assertions
  AST_INT_STROBES: assert property (@(posedge clk) disable iff (!rstn)
    (take && !is_external(eff, ext_mem_enable)) |=> ext_rd_n && ext_wr_n)
    else $error("external strobe active on internal access");
  AST_EXT_ENABLE: assert property (@(posedge clk) disable iff (!rstn)
    (!ext_mem_enable && busy_cnt == 4'h0) |-> ext_rd_n && ext_wr_n)
    else $error("external strobe active while interface disabled");
  AST_SRAM_TWO: assert property (@(posedge clk) disable iff (!rstn)
    (take && eff >= dmm_pkg::SRAM_FIRST && eff <= dmm_pkg::SRAM_LAST) |-> ##2 done)
    else $error("internal SRAM access not two cycles");
  AST_EXT_ZWS: assert property (@(posedge clk) disable iff (!rstn)
    (take && is_external(eff, ext_mem_enable) && wait_states == 2'h0 && !req.pc_xfer)
    |=> !done ##1 !done ##1 done)
    else $error("external zero-wait access not three cycles");
  AST_RD_STALL: assert property (@(posedge clk) disable iff (!rstn)
    nv_rd_go |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");
  AST_WR_STALL: assert property (@(posedge clk) disable iff (!rstn)
    nv_wr_go |=> cpu_stall [*2] ##1 !cpu_stall)
    else $error("write stall not two cycles");
  AST_ARM_TIMEOUT: assert property (@(posedge clk) disable iff (!rstn)
    $rose(nv_write_arm) |-> ##4 !nv_write_arm)
    else $error("arm did not time out after four cycles");
  AST_NO_UNARMED: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(nv_write_strobe)) |-> $past(nv_write_arm))
    else $error("write started without arming");
  AST_ADDR_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    (nv_write_strobe && $past(nv_write_strobe)) |-> $stable(nv_byte_address))
    else $error("address changed during write");

endmodule

/* File: verif/dmm_ext_sram.sv */
// Behavioural external SRAM that answers the block's external strobes.
`timescale 1ns/1ps
module dmm_ext_sram (
  input  wire logic        clk,
  input  wire logic [15:0] ext_addr,
  input  wire logic [7:0]  ext_wdata,
  input  wire logic        ext_rd_n,
  input  wire logic        ext_wr_n,
  output logic [7:0]       ext_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] junk = 8'h11;
  // ==========================================================================
  // Storage
  // A byte is stored on every edge that sees the write strobe low.
  always @(posedge clk) begin
    junk <= junk + 8'h3b;
    if (!ext_wr_n) begin
      mem[ext_addr] <= ext_wdata;
    end
  end
  // An idle bus shows a changing pattern, so stale data never matches by luck.
  assign ext_rdata = !ext_rd_n ? mem[ext_addr] : junk;
endmodule

/* File: verif/tb.sv */
// Self-checking testbench for the data memory map and nonvolatile byte port.
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic wr; logic [15:0] addr; logic [7:0] data; logic [1:0] ws; logic [1:0] sp;
    logic [15:0] lat;
  } dmm_tb_row_type;
  logic                 clk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 nv_osc_tick = 1'b1;
  logic                 pc_load = 1'b0;
  logic [11:0]          pc_next = 12'h000;
  logic [1:0]           wait_states = 2'h0;
  dmm_pkg::dmm_req_type req = '0;
  logic [11:0]          program_counter;
  logic [7:0]           ext_rdata, rdata, ext_wdata, got;
  logic                 done, cpu_stall, ext_rd_n, ext_wr_n, ext_on;
  logic [15:0]          ext_addr, ptr_x, ptr_y, ptr_z;
  int                   err_total, compares, cycles, lat, stl, k;
  // Ordinary accesses: write or read, address, data, wait states, stack/pc_xfer, latency.
  dmm_tb_row_type rows [14] = '{
    '{1, 16'h0055, 8'h80, 0, 0, 1}, '{1, 16'h0100, 8'h5a, 0, 0, 2},
    '{0, 16'h0100, 8'h5a, 0, 0, 2}, '{1, 16'h025f, 8'hc3, 0, 0, 2},
    '{0, 16'h025f, 8'hc3, 0, 0, 2}, '{1, 16'h0260, 8'h96, 0, 0, 3},
    '{0, 16'h0260, 8'h96, 0, 0, 3}, '{1, 16'hffff, 8'h69, 1, 0, 4},
    '{0, 16'hffff, 8'h69, 3, 0, 6}, '{1, 16'h8000, 8'h11, 0, 2, 3},
    '{1, 16'h8001, 8'h22, 0, 3, 5}, '{0, 16'h8001, 8'h22, 1, 3, 7},
    '{1, 16'h8002, 8'h33, 2, 3, 9}, '{0, 16'h8002, 8'h33, 3, 3, 11}};

  dmm_top dmm_top_inst (.clk(clk), .rstn(rstn), .req(req), .wait_states(wait_states),
    .nv_osc_tick(nv_osc_tick), .ext_rdata(ext_rdata), .pc_next(pc_next), .pc_load(pc_load),
    .program_counter(program_counter), .rdata(rdata), .done(done), .cpu_stall(cpu_stall),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
    .ptr_x(ptr_x), .ptr_y(ptr_y), .ptr_z(ptr_z));
  dmm_ext_sram dmm_ext_sram_inst (.clk(clk), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_rdata(ext_rdata));

  // ==========================================================================
  // Clock and hang guard
  always #50 clk = ~clk;
  // A full self-timed write takes 8448 cycles with the tick held high; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      end_sim();
    end
  end

  // ==========================================================================
  // Shared tasks
  // Closing report and verdict.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One comparison, counted; a mismatch is counted and reported at once.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One access: the latency and stall cycles land in lat and stl, read data in got.
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
      input logic [1:0] ws, input logic [1:0] sp, input dmm_pkg::dmm_mode_type md,
      input dmm_pkg::dmm_ptr_type pt, input logic [5:0] dp, input int tail);
    dmm_pkg::dmm_req_type r;
    logic intl;
    r = '0;
    r.valid = 1'b1;
    r.write = wr;
    r.stack = sp[1];
    r.pc_xfer = sp[0];
    r.mode = md;
    r.ptr = pt;
    r.direct = a;
    r.disp = dp;
    r.wdata = d;
    intl = (a < dmm_pkg::EXT_FIRST) || !ext_on;
    // The taking edge is cycle one, so a register access reports one cycle.
    lat = 1;
    stl = 0;
    @(posedge clk);
    req <= r;
    wait_states <= ws;
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    stl += int'(cpu_stall === 1'b1);
    while (done !== 1'b1 && lat < 40) begin
      @(posedge clk);
      #1;
      lat++;
      stl += int'(cpu_stall === 1'b1);
      if (intl) chk("ext_strobes", 16'h0003, {14'h0, ext_rd_n, ext_wr_n});
    end
    got = rdata;
    for (k = 0; k < tail; k++) begin
      @(posedge clk);
      #1;
      stl += int'(cpu_stall === 1'b1);
    end
  endtask
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 2'h0, 2'h0, dmm_pkg::AM_DIRECT, dmm_pkg::PTR_X, 6'h00, 8);
  endtask
  task automatic rd8(input logic [15:0] a);
    acc(1'b0, a, 8'h00, 2'h0, 2'h0, dmm_pkg::AM_DIRECT, dmm_pkg::PTR_X, 6'h00, 8);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    ext_on = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("idle_strobes", 16'h0003, {14'h0, ext_rd_n, ext_wr_n});
    chk("idle_done", 16'h0000, {14'h0, done, cpu_stall});
    rd8(16'h0260);
    chk("ext_off_read", 16'h0000, got);
    ext_on = 1'b1;
    foreach (rows[i]) begin
      acc(rows[i].wr, rows[i].addr, rows[i].data, rows[i].ws, rows[i].sp,
          dmm_pkg::AM_DIRECT, dmm_pkg::PTR_X, 6'h00, 8);
      chk("latency", rows[i].lat, 16'(lat));
      chk("stall", 16'h0000, 16'(stl));
      if (!rows[i].wr) chk("rdata", {8'h0, rows[i].data}, got);
    end
    // Post-increment, displacement and pre-decrement all reach SRAM byte 0x0100.
    wr8(16'h001a, 8'h00);
    wr8(16'h001b, 8'h01);
    wr8(16'h001c, 8'hc1);
    wr8(16'h001d, 8'h00);
    wr8(16'h001e, 8'h01);
    wr8(16'h001f, 8'h01);
    acc(1'b0, 16'h0100, 8'h00, 2'h0, 2'h0, dmm_pkg::AM_POSTINC, dmm_pkg::PTR_X, 6'h00, 8);
    chk("postinc_data", 16'h005a, got);
    chk("ptr_x", 16'h0101, ptr_x);
    acc(1'b0, 16'h0100, 8'h00, 2'h0, 2'h0, dmm_pkg::AM_DISP, dmm_pkg::PTR_Y, 6'h3f, 8);
    chk("disp_data", 16'h005a, got);
    acc(1'b0, 16'h0100, 8'h00, 2'h0, 2'h0, dmm_pkg::AM_PREDEC, dmm_pkg::PTR_Z, 6'h00, 8);
    chk("predec_data", 16'h005a, got);
    chk("ptr_z", 16'h0100, ptr_z);
    // Program counter load at its widest value.
    @(posedge clk);
    pc_next <= 12'hfff;
    pc_load <= 1'b1;
    @(posedge clk);
    pc_load <= 1'b0;
    #1;
    chk("program_counter", 16'h0fff, {4'h0, program_counter});
    // Nonvolatile port: address first, as software must, then the guarded write.
    wr8(16'h003f, 8'hff);
    rd8(16'h003f);
    chk("nv_address_high", 16'h0001, got);
    wr8(16'h003e, 8'h34);
    wr8(16'h003d, 8'h7e);
    wr8(16'h003c, 8'h02);
    rd8(16'h003c);
    chk("unarmed_write", 16'h0000, {15'h0, got[1]});
    wr8(16'h003c, 8'h04);
    wr8(16'h003c, 8'h02);
    rd8(16'h003c);
    chk("expired_arm", 16'h0000, {15'h0, got[1]});
    acc(1'b1, 16'h003c, 8'h04, 2'h0, 2'h0, dmm_pkg::AM_DIRECT, dmm_pkg::PTR_X, 6'h00, 0);
    wr8(16'h003c, 8'h02);
    chk("write_stall", 16'h0002, 16'(stl));
    rd8(16'h003c);
    chk("write_busy", 16'h0001, {15'h0, got[1]});
    wr8(16'h003e, 8'h99);
    wr8(16'h003d, 8'h7e);
    wr8(16'h003c, 8'h01);
    rd8(16'h003e);
    chk("addr_locked", 16'h0034, got);
    rd8(16'h003d);
    chk("read_blocked", 16'h007e, got);
    rd8(16'h003c);
    for (int n = 0; n < 12 && got[1] !== 1'b0; n++) begin
      repeat (1000) @(posedge clk);
      rd8(16'h003c);
    end
    chk("write_finished", 16'h0000, {15'h0, got[1]});
    wr8(16'h003c, 8'h01);
    chk("read_stall", 16'h0004, 16'(stl));
    rd8(16'h003d);
    chk("nv_byte_data", 16'h007e, got);
    end_sim();
  end
endmodule
